//--- inc/nvwp_pkg.sv
/* nvwp_pkg: opcodes, status bit layout, protected ranges, states and helpers
   for the serial write-protect and status block.
   assumes: compiled before every other file of the block. */
package nvwp_pkg;
	// ==========================================================
	// opcodes, sent msb first
	localparam logic [7:0] OP_ARM     = 8'h06;
	localparam logic [7:0] OP_DISARM  = 8'h04;
	localparam logic [7:0] OP_RD_STAT = 8'h05;
	localparam logic [7:0] OP_WR_STAT = 8'h01;
	localparam logic [7:0] OP_ARR_RD  = 8'h03;
	localparam logic [7:0] OP_ARR_WR  = 8'h02;
	localparam logic [7:0] OP_CLK_WR  = 8'h12;
	localparam logic [7:0] OP_SAVE    = 8'h3c;
	localparam logic [7:0] OP_RESTORE = 8'h60;
	localparam logic [7:0] OP_AS_ON   = 8'h59;
	localparam logic [7:0] OP_AS_OFF  = 8'h19;

	// ==========================================================
	// status byte layout
	localparam int unsigned B_BUSY = 0;
	localparam int unsigned B_WEL  = 1;
	localparam int unsigned B_BP0  = 2;
	localparam int unsigned B_BP1  = 3;
	localparam int unsigned B_PGE  = 7;
	localparam logic        WEL_RST = 1'b0;
	localparam logic [7:0]  STAT_RST = 8'h00;

	// ==========================================================
	// lowest guarded address per range setting
	localparam logic [16:0] GUARD_QTR  = 17'h18000;
	localparam logic [16:0] GUARD_HALF = 17'h10000;

	// ==========================================================
	// types
	typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_WSTAT, ST_RSTAT, ST_ARRAY, ST_SKIP} nvwp_st_t;
	typedef enum logic [2:0] {RQ_NONE, RQ_SAVE, RQ_RESTORE, RQ_AS_ON, RQ_AS_OFF} nvwp_rq_t;

	function automatic logic in_guard(input logic [1:0] bp, input logic [16:0] a);
		case (bp)
			2'h1:    in_guard = (a >= GUARD_QTR);
			2'h2:    in_guard = (a >= GUARD_HALF);
			2'h3:    in_guard = 1'b1;
			default: in_guard = 1'b0;
		endcase
	endfunction

	function automatic logic is_wtype(input logic [7:0] op);
		is_wtype = (op == OP_WR_STAT) || (op == OP_ARR_WR) || (op == OP_CLK_WR) ||
			(op == OP_SAVE) || (op == OP_RESTORE) || (op == OP_AS_ON) || (op == OP_AS_OFF);
	endfunction
endpackage

//--- inc/nvwp_xfer_if.sv
/* nvwp_xfer_if: carries received bytes from the serial-clock side to the core
   and the frozen status byte back.
   assumes: rx_byte holds still for a whole byte time after rx_tgl flips. */
`timescale 1ns/1ps
interface nvwp_xfer_if;
	logic [7:0] rx_byte;
	logic       rx_tgl;
	logic [7:0] tx_stat;
	modport link (output rx_byte, output rx_tgl, input tx_stat);
	modport core (input rx_byte, input rx_tgl, output tx_stat);
endinterface

//--- design/nvwp_sync.sv
/* nvwp_sync: three-stage synchroniser with agreement filter.
   assumes: inputs are levels or toggles from outside core_clk. */
`timescale 1ns/1ps
module nvwp_sync #(
	parameter int unsigned  W   = 4,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// levels
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} nvwp_sync_t;

	nvwp_sync_t y_reg, y_next;

	always_comb begin
		y_next.s1 = d_in;
		y_next.s2 = y_reg.s1;
		y_next.s3 = y_reg.s2;
		// take a change only once stages two and three agree
		y_next.q = (y_reg.s2 & y_reg.s3) | (y_reg.q & (y_reg.s2 ^ y_reg.s3));
		if (sys_rst) begin
			y_next = {RST, RST, RST, RST};
		end
	end

	always_ff @(posedge core_clk) begin
		y_reg <= y_next;
	end

	assign q_out = y_reg.q;
endmodule // nvwp_sync

//--- design/nvwp_spi_link.sv
/* nvwp_spi_link: serial-clock side; assembles bytes, shifts out status.
   assumes: sck only moves while cs_n is low; mode 0 or 3. */
`timescale 1ns/1ps
module nvwp_spi_link (
	// reset
	input  wire logic  sys_rst,
	// serial pins
	input  wire logic  cs_n,
	input  wire logic  sck,
	input  wire logic  si,
	output logic       so_out,
	output logic       so_oe,
	// core side
	nvwp_xfer_if.link  xf
);
	typedef struct packed {
		logic [2:0] bit_cnt;
		logic [6:0] sh;
		logic       first;
		logic       send;
		logic [7:0] tx;
	} nvwp_frm_t;
	typedef struct packed {
		logic [7:0] rx_byte;
		logic       tgl;
	} nvwp_keep_t;
	typedef struct packed {
		logic so;
		logic oe;
	} nvwp_out_t;

	nvwp_frm_t  f_reg, f_next;
	nvwp_keep_t k_reg, k_next;
	nvwp_out_t  o_reg, o_next;
	logic       frame_rst;
	logic [7:0] got;

	// deselect wipes the frame; the toggle must survive frames
	assign frame_rst = cs_n | sys_rst;
	assign got       = {f_reg.sh, si};

	always_comb begin
		f_next = f_reg;
		k_next = k_reg;
		f_next.bit_cnt = f_reg.bit_cnt + 3'h1;
		f_next.sh = {f_reg.sh[5:0], si};
		f_next.tx = {f_reg.tx[6:0], 1'b0};
		if (f_reg.bit_cnt == 3'h7) begin
			k_next.rx_byte = got;
			k_next.tgl = ~k_reg.tgl;
			f_next.first = 1'b0;
			if (f_reg.first && got == nvwp_pkg::OP_RD_STAT) begin
				f_next.send = 1'b1;
			end
			f_next.tx = xf.tx_stat;
		end
		o_next.so = f_reg.tx[7];
		o_next.oe = f_reg.send;
	end

	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			f_reg <= {3'h0, 7'h00, 1'b1, 1'b0, 8'h00};
		end else begin
			f_reg <= f_next;
		end
	end

	always_ff @(posedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			k_reg <= '0;
		end else begin
			k_reg <= k_next;
		end
	end

	// output changes on the falling edge
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			o_reg <= '0;
		end else begin
			o_reg <= o_next;
		end
	end

	assign xf.rx_byte = k_reg.rx_byte;
	assign xf.rx_tgl  = k_reg.tgl;
	assign so_out     = o_reg.so;
	assign so_oe      = o_reg.oe;
endmodule // nvwp_spi_link

//--- design/nvwp_guard_core.sv
/* nvwp_guard_core: status byte, write-enable latch, range and pin guard,
   command gating for array, clock-register and save/restore commands.
   assumes: array path and save engine run on core_clk; sck is a separate
   clock that stands still outside frames. */
`timescale 1ns/1ps
// Function
// - status byte: busy bit0, write latch bit1, range bits 2-3, pin guard bit7
// - busy reads 1 while a save or restore cycle runs
// - status write changes only bits 2, 3 and 7
// - status write opcode then one data byte sets writable bits
// - write-type commands ignored while latch is 0, until deselect
// - power-up leaves writes disabled
// - arm command sets the write latch
// - latch cleared when any write-type command completes
// - disarm command clears latch at the deselect ending it
// - range bits pick none, top quarter, top half or whole array
// - writes into the guarded range are discarded, reads unaffected
// - pin low with pin guard set blocks status writes
// - pin guard clear makes the pin level irrelevant
// - pin falling during a status write does not stop it
// - array read and write refused while busy
// - status values reach nonvolatile storage only by a save
// - read-status opcode then status byte shifted out
// - opcodes: arm 06, disarm 04, read status 05
// - write status 01; all bytes msb first; frame starts at select
// - reset clears latch, reloads range and pin guard bits from nv_guard_bits
module nvwp_guard_core (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        sck,
	// serial pins
	input  wire logic        cs_n,
	input  wire logic        si,
	output logic             so_out,
	output logic             so_oe,
	// protect and busy pins
	input  wire logic        wp_n,
	input  wire logic        hw_save_busy_pin_n,
	// save engine
	input  wire logic        nv_busy,
	input  wire logic [2:0]  nv_guard_bits,
	output logic [7:0]       stat_out,
	output logic             save_req,
	output logic             restore_req,
	output logic             autosave_on_req,
	output logic             autosave_off_req,
	// array path
	input  wire logic        arr_wr_req,
	input  wire logic [16:0] arr_wr_addr,
	output logic             arr_open,
	output logic             arr_write,
	output logic             arr_wr_allow
);
	// ==========================================================
	// state
	typedef struct packed {
		nvwp_pkg::nvwp_st_t st;
		logic               wel;
		logic [1:0]         bp;
		logic               pge;
		logic               end_clr;
		nvwp_pkg::nvwp_rq_t rq;
		logic               tgl_seen;
		logic [7:0]         tx_hold;
		logic [7:0]         stat;
		logic               arr_open;
		logic               arr_write;
		logic               wr_allow;
		logic               save_req;
		logic               restore_req;
		logic               as_on_req;
		logic               as_off_req;
	} nvwp_core_t;

	nvwp_core_t  s_reg, s_next;
	nvwp_xfer_if xf ();
	logic [3:0]  sq;
	logic        cs_s;
	logic        wp_s;
	logic        hsb_s;
	logic        ev;
	logic        busy;
	logic [7:0]  rx;
	logic [7:0]  stat_v;

	// ==========================================================
	// link side and crossings
	nvwp_spi_link u_link (
		.sys_rst (sys_rst),
		.cs_n    (cs_n),
		.sck     (sck),
		.si      (si),
		.so_out  (so_out),
		.so_oe   (so_oe),
		.xf      (xf.link)
	);

	nvwp_sync #(.W(4), .RST(4'h7)) u_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.d_in     ({xf.rx_tgl, hw_save_busy_pin_n, wp_n, cs_n}),
		.q_out    (sq)
	);

	assign cs_s  = sq[0];
	assign wp_s  = sq[1];
	assign hsb_s = sq[2];
	assign ev    = sq[3] ^ s_reg.tgl_seen;
	assign rx    = xf.rx_byte;
	assign busy  = nv_busy | ~hsb_s;
	// frozen while selected so the link never samples a moving byte
	assign xf.tx_stat = s_reg.tx_hold;

	// ==========================================================
	// next state
	always_comb begin
		s_next = s_reg;
		s_next.tgl_seen = sq[3];
		s_next.wr_allow = 1'b0;
		s_next.save_req = 1'b0;
		s_next.restore_req = 1'b0;
		s_next.as_on_req = 1'b0;
		s_next.as_off_req = 1'b0;
		stat_v = nvwp_pkg::STAT_RST;
		stat_v[nvwp_pkg::B_BUSY] = busy;
		stat_v[nvwp_pkg::B_WEL] = s_reg.wel;
		stat_v[nvwp_pkg::B_BP0] = s_reg.bp[0];
		stat_v[nvwp_pkg::B_BP1] = s_reg.bp[1];
		stat_v[nvwp_pkg::B_PGE] = s_reg.pge;
		s_next.stat = stat_v;
		if (cs_s) begin
			s_next.tx_hold = stat_v;
		end
		if (s_reg.st == nvwp_pkg::ST_IDLE && !cs_s) begin
			s_next.st = nvwp_pkg::ST_OPC;
		end
		if (ev && s_reg.st == nvwp_pkg::ST_OPC) begin
			s_next.st = nvwp_pkg::ST_SKIP;
			if (nvwp_pkg::is_wtype(rx) && !s_reg.wel) begin
				s_next.st = nvwp_pkg::ST_SKIP;
			end else begin
				case (rx)
					nvwp_pkg::OP_ARM: begin
						s_next.wel = 1'b1;
					end
					nvwp_pkg::OP_DISARM: begin
						s_next.end_clr = 1'b1;
					end
					nvwp_pkg::OP_RD_STAT: begin
						s_next.st = nvwp_pkg::ST_RSTAT;
					end
					nvwp_pkg::OP_WR_STAT: begin
						// pin judged at the opcode only; a later fall is ignored
						if (wp_s || !s_reg.pge) begin
							s_next.st = nvwp_pkg::ST_WSTAT;
						end
					end
					nvwp_pkg::OP_ARR_RD: begin
						if (!busy) begin
							s_next.st = nvwp_pkg::ST_ARRAY;
							s_next.arr_open = 1'b1;
						end
					end
					nvwp_pkg::OP_ARR_WR: begin
						if (!busy) begin
							s_next.st = nvwp_pkg::ST_ARRAY;
							s_next.arr_open = 1'b1;
							s_next.arr_write = 1'b1;
							s_next.end_clr = 1'b1;
						end
					end
					nvwp_pkg::OP_CLK_WR: begin
						s_next.end_clr = 1'b1;
					end
					nvwp_pkg::OP_SAVE: begin
						s_next.end_clr = 1'b1;
						s_next.rq = nvwp_pkg::RQ_SAVE;
					end
					nvwp_pkg::OP_RESTORE: begin
						s_next.end_clr = 1'b1;
						s_next.rq = nvwp_pkg::RQ_RESTORE;
					end
					nvwp_pkg::OP_AS_ON: begin
						s_next.end_clr = 1'b1;
						s_next.rq = nvwp_pkg::RQ_AS_ON;
					end
					nvwp_pkg::OP_AS_OFF: begin
						s_next.end_clr = 1'b1;
						s_next.rq = nvwp_pkg::RQ_AS_OFF;
					end
					default: begin
						s_next.st = nvwp_pkg::ST_SKIP;
					end
				endcase
			end
		end else if (ev && s_reg.st == nvwp_pkg::ST_WSTAT) begin
			// latch and busy bits of the data byte are dropped
			s_next.st = nvwp_pkg::ST_SKIP;
			s_next.pge = rx[nvwp_pkg::B_PGE];
			s_next.bp = {rx[nvwp_pkg::B_BP1], rx[nvwp_pkg::B_BP0]};
			s_next.end_clr = 1'b1;
		end
		if (arr_wr_req && s_reg.arr_write &&
			!nvwp_pkg::in_guard(s_reg.bp, arr_wr_addr)) begin
			s_next.wr_allow = 1'b1;
		end
		// deselect: ends the frame, settles deferred effects
		if (cs_s && s_reg.st != nvwp_pkg::ST_IDLE) begin
			s_next.st = nvwp_pkg::ST_IDLE;
			if (s_next.end_clr) begin
				s_next.wel = 1'b0;
			end
			s_next.save_req = (s_next.rq == nvwp_pkg::RQ_SAVE);
			s_next.restore_req = (s_next.rq == nvwp_pkg::RQ_RESTORE);
			s_next.as_on_req = (s_next.rq == nvwp_pkg::RQ_AS_ON);
			s_next.as_off_req = (s_next.rq == nvwp_pkg::RQ_AS_OFF);
			s_next.rq = nvwp_pkg::RQ_NONE;
			s_next.end_clr = 1'b0;
			s_next.arr_open = 1'b0;
			s_next.arr_write = 1'b0;
		end
		if (sys_rst) begin
			s_next = '0;
			s_next.st = nvwp_pkg::ST_IDLE;
			s_next.rq = nvwp_pkg::RQ_NONE;
			s_next.wel = nvwp_pkg::WEL_RST;
			{s_next.pge, s_next.bp} = nv_guard_bits;
		end
	end

	always_ff @(posedge core_clk) begin
		s_reg <= s_next;
	end

	// ==========================================================
	// outputs
	assign stat_out         = s_reg.stat;
	assign save_req         = s_reg.save_req;
	assign restore_req      = s_reg.restore_req;
	assign autosave_on_req  = s_reg.as_on_req;
	assign autosave_off_req = s_reg.as_off_req;
	assign arr_open         = s_reg.arr_open;
	assign arr_write        = s_reg.arr_write;
	assign arr_wr_allow     = s_reg.wr_allow;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_busy_flag: assert property (busy |=> s_reg.stat[nvwp_pkg::B_BUSY])
		else $error("busy not shown in status");
	a_unused_zero: assert property (s_reg.stat[6:4] == 3'h0 && s_reg.tx_hold[6:4] == 3'h0)
		else $error("unused status bits not zero");
	a_wstat_bits: assert property (ev && s_reg.st == nvwp_pkg::ST_WSTAT && !cs_s
		|=> s_reg.wel == $past(s_reg.wel) && s_reg.bp == $past(rx[3:2]) && s_reg.pge == $past(rx[7]))
		else $error("status write changed wrong bits");
	a_pin_lock: assert property (ev && s_reg.st == nvwp_pkg::ST_OPC && rx == nvwp_pkg::OP_WR_STAT
		&& !wp_s && s_reg.pge |=> s_reg.st != nvwp_pkg::ST_WSTAT)
		else $error("status write accepted under pin lock");
	a_pin_free: assert property (ev && s_reg.st == nvwp_pkg::ST_OPC && !cs_s && s_reg.wel
		&& rx == nvwp_pkg::OP_WR_STAT && !s_reg.pge |=> s_reg.st == nvwp_pkg::ST_WSTAT)
		else $error("status write refused with pin guard off");
	a_arm_set: assert property (ev && s_reg.st == nvwp_pkg::ST_OPC
		&& rx == nvwp_pkg::OP_ARM |=> s_reg.wel)
		else $error("arm did not set latch");
	a_no_arm: assert property (ev && s_reg.st == nvwp_pkg::ST_OPC && !s_reg.wel && !cs_s
		&& nvwp_pkg::is_wtype(rx) |=> s_reg.st == nvwp_pkg::ST_SKIP && !s_reg.arr_open
		&& s_reg.rq == nvwp_pkg::RQ_NONE ##1 !s_reg.wel)
		else $error("write-type command taken while disarmed");
	a_end_clear: assert property (cs_s && s_reg.st != nvwp_pkg::ST_IDLE && s_reg.end_clr
		|=> !s_reg.wel && s_reg.st == nvwp_pkg::ST_IDLE)
		else $error("latch not cleared at deselect");
	a_guard_drop: assert property (arr_wr_req && nvwp_pkg::in_guard(s_reg.bp, arr_wr_addr)
		|=> !s_reg.wr_allow)
		else $error("write allowed into guarded range");
	a_busy_refuse: assert property (ev && s_reg.st == nvwp_pkg::ST_OPC && busy &&
		(rx == nvwp_pkg::OP_ARR_RD || rx == nvwp_pkg::OP_ARR_WR) |=> !s_reg.arr_open)
		else $error("array opened while busy");
	a_reset_disarm: assert property (disable iff (1'b0) sys_rst |=> !s_reg.wel
		&& {s_reg.pge, s_reg.bp} == $past(nv_guard_bits))
		else $error("reset state wrong");
	a_snap_hold: assert property (!cs_s ##1 !cs_s |-> $stable(s_reg.tx_hold))
		else $error("status snapshot moved while selected");
	a_link_quiet: assert property (cs_s |-> !so_oe)
		else $error("serial output enabled while deselected");
	a_req_disarm: assert property (s_reg.save_req || s_reg.restore_req || s_reg.as_on_req
		|| s_reg.as_off_req |-> !s_reg.wel)
		else $error("request issued with latch still set");
	a_allow_cause: assert property (s_reg.wr_allow
		|-> $past(arr_wr_req) && $past(s_reg.arr_write))
		else $error("write allowed without an accepted array write");

	c_arm: cover property (ev && s_reg.st == nvwp_pkg::ST_OPC && rx == nvwp_pkg::OP_ARM);
	c_wstat: cover property (ev && s_reg.st == nvwp_pkg::ST_WSTAT);
	c_rstat: cover property (s_reg.st == nvwp_pkg::ST_RSTAT ##1 cs_s);
	c_wr_ok: cover property (s_reg.wr_allow);
	c_guard_hit: cover property (arr_wr_req && s_reg.arr_write &&
		nvwp_pkg::in_guard(s_reg.bp, arr_wr_addr));
endmodule // nvwp_guard_core

//--- bench/nvwp_host_model.sv
/* nvwp_host_model: behavioural spi host in mode 0 that frames single commands.
   assumes: device samples si on sck rising and shifts so on sck falling;
   the 48 ns serial clock stands still outside frames. */
`timescale 1ns/1ps
module nvwp_host_model (
	// serial pins
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so_out,
	input  wire logic so_oe
);
	// ==========================================================
	// idle levels
	initial begin
		sck  = 1'b0;
		si   = 1'b1;
		// deselect after time zero so the frame reset sees a real edge
		#1;
		cs_n = 1'b1;
	end

	// ==========================================================
	// one frame: opcode and an optional data byte; rx keeps the last 8 bits on so
	task automatic send(input logic [7:0] op, input logic two, input logic [7:0] dat,
		output logic [7:0] rx, output logic oe_ok);
		logic [15:0] sh;
		int          n;
		sh = {op, dat};
		n = two ? 16 : 8;
		rx = 8'h00;
		oe_ok = 1'b1;
		cs_n = 1'b0;
		// offset keeps sck out of phase with core_clk
		#53;
		for (int i = 0; i < n; i++) begin
			si = sh[15 - i];
			#24;
			sck = 1'b1;
			rx = {rx[6:0], so_out};
			if (i >= 8)
				oe_ok = oe_ok & (so_oe === 1'b1);
			#24;
			sck = 1'b0;
		end
		// cs_n held well past the last rising edge
		#60;
		cs_n = 1'b1;
		// released line shows the inverse, never the last value
		si = ~si;
		#80;
	endtask
endmodule // nvwp_host_model

//--- bench/testbench.sv
/* testbench: random and corner checks of the status, latch and guard block.
   assumes: nvwp_pkg compiled first; host model owns the serial pins. */
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// signals
	logic        core_clk;
	logic        sys_rst;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic        so_out;
	logic        so_oe;
	logic        wp_n;
	logic        hw_save_busy_pin_n;
	logic        nv_busy;
	logic [2:0]  nv_guard_bits;
	logic [7:0]  stat_out;
	logic [4:0]  rq;
	logic        arr_wr_req;
	logic [16:0] arr_wr_addr;
	logic        arr_open;
	logic        arr_write;
	logic        arr_wr_allow;
	logic [1:0]  e_bp;
	logic        e_pge;
	logic        e_wel;
	logic [7:0]  rx;
	logic        oe;
	logic [31:0] seed;
	int          errors;
	int          check_count;
	int          pc[5];
	int          p0[5];

	nvwp_guard_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
		.si(si), .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n),
		.hw_save_busy_pin_n(hw_save_busy_pin_n), .nv_busy(nv_busy),
		.nv_guard_bits(nv_guard_bits), .stat_out(stat_out), .save_req(rq[0]),
		.restore_req(rq[1]), .autosave_on_req(rq[2]), .autosave_off_req(rq[3]),
		.arr_wr_req(arr_wr_req), .arr_wr_addr(arr_wr_addr), .arr_open(arr_open),
		.arr_write(arr_write), .arr_wr_allow(arr_wr_allow));
	nvwp_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe));

	// ==========================================================
	// clock, pulse counters, watchdog
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	assign rq[4] = arr_open;
	always @(posedge core_clk)
		for (int k = 0; k < 5; k++)
			if (rq[k] === 1'b1)
				pc[k]++;
	initial begin
		#400000;
		errors++;
		wrap_up();
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] exp_stat();
		return {e_pge, 3'h0, e_bp, e_wel, nv_busy | ~hw_save_busy_pin_n};
	endfunction
	function automatic logic guarded(input logic [1:0] bp, input logic [16:0] a);
		return (bp == 2'h3) || (bp == 2'h2 && a >= 17'h10000) || (bp == 2'h1 && a >= 17'h18000);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic two, input logic [7:0] dat);
		host.send(op, two, dat, rx, oe);
		repeat (6) @(posedge core_clk);
		#1;
	endtask
	task automatic rd_check();
		cmd(nvwp_pkg::OP_RD_STAT, 1'b1, 8'h00);
		check(rx, exp_stat());
		check({7'h0, oe}, 8'h01);
		check(stat_out, exp_stat());
	endtask
	task automatic arm();
		cmd(nvwp_pkg::OP_ARM, 1'b0, 8'h00);
		e_wel = 1'b1;
		check(stat_out, exp_stat());
	endtask
	task automatic do_reset(input logic [2:0] nv);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		nv_guard_bits <= nv;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		{e_pge, e_bp} = nv;
		e_wel = 1'b0;
		check(stat_out, exp_stat());
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// tests
	initial begin
		logic [7:0]  d;
		logic [7:0]  ops[5];
		logic [16:0] ad[7];
		seed = 32'he5559eee;
		errors = 0;
		check_count = 0;
		sys_rst = 1'b0;
		wp_n = 1'b1;
		hw_save_busy_pin_n = 1'b1;
		nv_busy = 1'b0;
		nv_guard_bits = 3'h0;
		arr_wr_req = 1'b0;
		arr_wr_addr = 17'h0;
		ops = '{nvwp_pkg::OP_SAVE, nvwp_pkg::OP_RESTORE, nvwp_pkg::OP_AS_ON,
			nvwp_pkg::OP_AS_OFF, nvwp_pkg::OP_CLK_WR};
		// link resets are edge triggered: raise reset after time zero
		#1 sys_rst = 1'b1;
		do_reset({1'b0, 2'(rnd() >> 30)});
		rd_check();
		d = 8'(rnd());
		cmd(nvwp_pkg::OP_WR_STAT, 1'b1, d);
		check(stat_out, exp_stat());
		// pin low but pin guard clear: write goes through, fixed bits untouched
		wp_n <= 1'b0;
		arm();
		d = 8'(rnd()) & 8'h7f;
		cmd(nvwp_pkg::OP_WR_STAT, 1'b1, d);
		{e_pge, e_bp, e_wel} = {d[7], d[3:2], 1'b0};
		check(stat_out, exp_stat());
		wp_n <= 1'b1;
		arm();
		d = 8'(rnd()) | 8'h80;
		cmd(nvwp_pkg::OP_WR_STAT, 1'b1, d);
		{e_pge, e_bp, e_wel} = {d[7], d[3:2], 1'b0};
		rd_check();
		wp_n <= 1'b0;
		arm();
		cmd(nvwp_pkg::OP_WR_STAT, 1'b1, ~d);
		check(stat_out, exp_stat());
		// latch still set; pin falls in mid frame
		wp_n <= 1'b1;
		d = 8'(rnd());
		fork
			host.send(nvwp_pkg::OP_WR_STAT, 1'b1, d, rx, oe);
			begin
				repeat (60) @(posedge core_clk);
				wp_n <= 1'b0;
			end
		join
		repeat (6) @(posedge core_clk);
		#1;
		{e_pge, e_bp, e_wel} = {d[7], d[3:2], 1'b0};
		check(stat_out, exp_stat());
		wp_n <= 1'b1;
		arm();
		cmd(nvwp_pkg::OP_DISARM, 1'b0, 8'h00);
		e_wel = 1'b0;
		rd_check();
		$display("test status done");
		for (int k = 0; k < 5; k++) begin
			for (int r = 0; r < 2; r++) begin
				if (r == 1)
					arm();
				p0 = pc;
				cmd(ops[k], 1'b0, 8'h00);
				e_wel = 1'b0;
				for (int j = 0; j < 4; j++)
					check(8'(pc[j] - p0[j]), {7'h0, (j == k) && (r == 1)});
				check(stat_out, exp_stat());
			end
		end
		$display("test write commands done");
		nv_busy <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd_check();
		arm();
		for (int b = 0; b < 2; b++) begin
			p0 = pc;
			cmd(b ? nvwp_pkg::OP_ARR_RD : nvwp_pkg::OP_ARR_WR, 1'b1, 8'(rnd()));
			check({7'h0, pc[4] != p0[4]}, 8'h00);
			check(stat_out, exp_stat());
			nv_busy <= 1'b0;
			hw_save_busy_pin_n <= 1'b0;
			repeat (6) @(posedge core_clk);
		end
		rd_check();
		hw_save_busy_pin_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		p0 = pc;
		cmd(nvwp_pkg::OP_ARR_RD, 1'b1, 8'h00);
		check({7'h0, pc[4] != p0[4]}, 8'h01);
		$display("test busy done");
		for (int bp = 0; bp < 4; bp++) begin
			arm();
			cmd(nvwp_pkg::OP_WR_STAT, 1'b1, {4'h0, bp[1:0], 2'h0});
			{e_pge, e_bp, e_wel} = {1'b0, bp[1:0], 1'b0};
			arm();
			ad = '{17'h0, 17'h0ffff, 17'h10000, 17'h17fff, 17'h18000, 17'h1ffff, 17'(rnd())};
			fork
				host.send(nvwp_pkg::OP_ARR_WR, 1'b1, 8'h5a, rx, oe);
				begin
					for (int t = 0; t < 100 && arr_open !== 1'b1; t++)
						@(posedge core_clk);
					check({7'h0, arr_write}, 8'h01);
					foreach (ad[i]) begin
						@(posedge core_clk);
						arr_wr_req <= 1'b1;
						arr_wr_addr <= ad[i];
						@(posedge core_clk);
						arr_wr_req <= 1'b0;
						#1;
						check({7'h0, arr_wr_allow}, {7'h0, !guarded(bp[1:0], ad[i])});
					end
				end
			join
			repeat (6) @(posedge core_clk);
			#1;
			e_wel = 1'b0;
			check(stat_out, exp_stat());
			check({7'h0, oe}, 8'h00);
		end
		$display("test guard done");
		do_reset(3'(rnd()));
		rd_check();
		$display("test reset done");
		wrap_up();
	end
endmodule // testbench
